// File: pcg_clock_gen.sv
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module pcg_clock_gen #(
  parameter logic [15:0] XTAL_START_TICKS = 16'h0400
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rc_tick,
  input  wire logic        crystal_tick,
  input  wire logic        core_osc_tick,
  input  wire logic        aclk_tick,
  input  wire logic        stop_mode,
  output logic             crystal_enable,
  output logic [1:0]       ref_range_select,
  output logic [1:0]       core_range_select,
  output logic             pump_up,
  output logic             pump_dn,
  output logic             loop_output_clock,
  output logic             bus_tick,
  output logic             lock_irq,
  output logic             crystal_irq,
  output logic             watchdog_run
);
  import pcg_pkg::*;

  pcg_cfg_s    cfg_q, cfg_d;
  pcg_ctl_s    ctl_q, ctl_d;
  logic        osc_en_d, osc_wr, access, wr_en, addr_ok;
  logic        pready_d, slverr_d;
  logic [31:0] prdata_d;
  logic        reference_clock, feedback_clock, ref_src;
  logic [3:0]  pre_div;
  logic [4:0]  out_div;
  logic        fbh_q, fbh_d, up_d, dn_d, fb_pd;
  logic [7:0]  ref_cnt_q, ref_cnt_d;
  logic [8:0]  fb_cnt_q, fb_cnt_d, fb_err;
  logic        lock_q, lock_d, win_end, lirq_d;
  logic [15:0] xcnt_q, xcnt_d;
  logic [7:0]  idle_q, idle_d;
  logic        stab_q, stab_d, xirq_d;
  pcg_sel_e    st_q, st_d;
  logic        src_q, src_d, half_q, half_d, cur_tick, bus_d;
  logic [1:0]  wd_cnt_q, wd_cnt_d;
  logic        wd_d;

  // =====================================================================
  // apb slave: setup, one wait cycle, then pready with data
  assign access  = psel && penable;
  assign wr_en   = access && pready && pwrite;
  assign addr_ok = (paddr == ADDR_CFG) || (paddr == ADDR_CTRL) ||
                   (paddr == ADDR_OSC) || (paddr == ADDR_STAT);

  // read data is latched in the wait cycle so prdata comes from a flop
  always_comb begin
    pready_d = access && !pready;
    prdata_d = prdata;
    slverr_d = pslverr;
    if (access && !pready) begin
      slverr_d = !addr_ok;
      prdata_d = '0;
      case (paddr)
        ADDR_CFG:  prdata_d[CFG_W-1:0] = cfg_q;
        ADDR_CTRL: prdata_d[CTL_W-1:0] = ctl_q;
        ADDR_OSC:  prdata_d[OSC_EN]    = crystal_enable;
        ADDR_STAT: begin
          prdata_d[ST_LOCK] = lock_q;
          prdata_d[ST_XSTB] = stab_q;
          prdata_d[ST_BUSX] = !src_q;
        end
        default:   prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_d;
      prdata  <= prdata_d;
      pslverr <= slverr_d;
    end
  end

  // =====================================================================
  // software registers
  // oscillator register only accepts writes while loop_clock_select picks the loop
  assign osc_wr = wr_en && (paddr == ADDR_OSC) && ctl_q.loop_clock_select;

  always_comb begin
    cfg_d    = cfg_q;
    ctl_d    = ctl_q;
    osc_en_d = crystal_enable;
    if (wr_en && paddr == ADDR_CFG) begin
      cfg_d = pwdata[CFG_W-1:0];
    end
    if (wr_en && paddr == ADDR_CTRL) begin
      ctl_d = pwdata[CTL_W-1:0];
    end
    if (osc_wr) begin
      osc_en_d = pwdata[OSC_EN];
    end
    // no crystal bus without a stable crystal; the forced set beats a clear
    if (!ctl_d.loop_clock_select && !stab_d) begin
      ctl_d.loop_clock_select = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q          <= CFG_RST;
      ctl_q          <= CTL_RST;
      crystal_enable <= 1'b0;
    end else begin
      cfg_q          <= cfg_d;
      ctl_q          <= ctl_d;
      crystal_enable <= osc_en_d;
    end
  end

  assign ref_range_select  = cfg_q.ref_range_select;
  assign core_range_select = cfg_q.core_range_select;

  // =====================================================================
  // dividers: reference, feedback, loop output
  assign ref_src = crystal_enable ? crystal_tick : rc_tick;
  assign pre_div = crystal_enable ? cfg_q.ref_predivider : 4'h0;
  assign out_div = lock_q ? cfg_q.output_divider : UNLOCK_DIV;

  pcg_divider #(.WIDTH(4)) u_pre (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (ref_src),
    .div      (pre_div),
    .tick_out (reference_clock)
  );

  pcg_divider #(.WIDTH(6)) u_fb (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (core_osc_tick),
    .div      (cfg_q.loop_multiplier),
    .tick_out (feedback_clock)
  );

  pcg_divider #(.WIDTH(5)) u_out (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (core_osc_tick),
    .div      (out_div),
    .tick_out (loop_output_clock)
  );

  // =====================================================================
  // phase detector; feedback halved so the loop settles at 2x multiplier
  assign fb_pd = feedback_clock && fbh_q;

  always_comb begin
    fbh_d = fbh_q ^ feedback_clock;
    up_d  = pump_up || reference_clock;
    dn_d  = pump_dn || fb_pd;
    // both edges seen: cancel, the width of the lone pulse is the error
    if (up_d && dn_d) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fbh_q   <= 1'b0;
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
    end else begin
      fbh_q   <= fbh_d;
      pump_up <= up_d;
      pump_dn <= dn_d;
    end
  end

  // =====================================================================
  // lock detector: feedback count over a window of reference ticks,
  // so detection time scales with the reference period
  assign win_end = reference_clock && (ref_cnt_q == LOCK_LAST);
  assign fb_err  = (fb_cnt_q > FB_EXPECT) ? fb_cnt_q - FB_EXPECT
                                          : FB_EXPECT - fb_cnt_q;

  always_comb begin
    ref_cnt_d = ref_cnt_q;
    fb_cnt_d  = fb_cnt_q;
    lock_d    = lock_q;
    if (feedback_clock && fb_cnt_q != FB_MAX) begin
      fb_cnt_d = fb_cnt_q + 9'h001;
    end
    if (reference_clock) begin
      ref_cnt_d = ref_cnt_q + 8'h01;
    end
    if (win_end) begin
      ref_cnt_d = '0;
      fb_cnt_d  = '0;
      // hysteresis: tight band to lock, wider band to drop it
      if (!lock_q && fb_err <= LOCK_TOL) begin
        lock_d = 1'b1;
      end else if (lock_q && fb_err > UNL_TOL) begin
        lock_d = 1'b0;
      end
    end
    if (osc_wr) begin
      ref_cnt_d = '0;
      fb_cnt_d  = '0;
      lock_d    = 1'b0;
    end
    lirq_d = ctl_q.lock_irq_enable && (lock_d != lock_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= '0;
      fb_cnt_q  <= '0;
      lock_q    <= 1'b0;
      lock_irq  <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      fb_cnt_q  <= fb_cnt_d;
      lock_q    <= lock_d;
      lock_irq  <= lirq_d;
    end
  end

  // =====================================================================
  // crystal start-up and loss monitor
  always_comb begin
    xcnt_d = xcnt_q;
    idle_d = crystal_tick ? 8'h00 : idle_q;
    stab_d = stab_q;
    if (!crystal_tick && idle_q != XTAL_LOSS_CYC) begin
      idle_d = idle_q + 8'h01;
    end
    if (crystal_tick && !stab_q) begin
      xcnt_d = xcnt_q + 16'h0001;
      if (xcnt_d >= XTAL_START_TICKS) begin
        stab_d = 1'b1;
      end
    end
    // losing lock or the crystal itself drops the stable status
    if (!crystal_enable || osc_wr || (lock_q && !lock_d) ||
        (stab_q && idle_q == XTAL_LOSS_CYC)) begin
      xcnt_d = '0;
      stab_d = 1'b0;
    end
    xirq_d = ctl_q.crystal_irq_enable && (stab_d != stab_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcnt_q      <= '0;
      idle_q      <= '0;
      stab_q      <= 1'b0;
      crystal_irq <= 1'b0;
    end else begin
      xcnt_q      <= xcnt_d;
      idle_q      <= idle_d;
      stab_q      <= stab_d;
      crystal_irq <= xirq_d;
    end
  end

  // =====================================================================
  // bus source switch: drain one old period, then skip one new tick,
  // so no gap is shorter than either period
  assign cur_tick = src_q ? (loop_output_clock && half_q) : crystal_tick;

  always_comb begin
    st_d   = st_q;
    src_d  = src_q;
    half_d = half_q ^ loop_output_clock;
    bus_d  = 1'b0;
    case (st_q)
      SEL_RUN: begin
        bus_d = cur_tick;
        if (ctl_q.loop_clock_select != src_q) begin
          st_d = SEL_DRAIN;
        end
      end
      SEL_DRAIN: begin
        if (cur_tick) begin
          src_d = ctl_q.loop_clock_select;
          st_d  = SEL_SYNC;
        end
      end
      SEL_SYNC: begin
        if (cur_tick) begin
          st_d = SEL_RUN;
        end
      end
      default: st_d = SEL_RUN;
    endcase
    // a dead crystal never ends the wait; go straight to the loop and
    // swallow any last crystal tick so no runt reaches the bus
    if (!src_q && !stab_q) begin
      src_d = 1'b1;
      st_d  = SEL_SYNC;
      bus_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= SEL_RUN;
      src_q    <= 1'b1;
      half_q   <= 1'b0;
      bus_tick <= 1'b0;
    end else begin
      st_q     <= st_d;
      src_q    <= src_d;
      half_q   <= half_d;
      bus_tick <= bus_d;
    end
  end

  // =====================================================================
  // watchdog run gate around stop mode
  always_comb begin
    wd_cnt_d = wd_cnt_q;
    wd_d     = watchdog_run;
    if (stop_mode) begin
      wd_cnt_d = '0;
      wd_d     = !ctl_q.watchdog_stop_disable;
    end else if (!watchdog_run && aclk_tick) begin
      // slow clock crossing costs two ticks before counting resumes
      wd_cnt_d = wd_cnt_q + 2'h1;
      wd_d     = (wd_cnt_d == WD_RESUME);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q     <= '0;
      watchdog_run <= 1'b1;
    end else begin
      wd_cnt_q     <= wd_cnt_d;
      watchdog_run <= wd_d;
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rc_reference_a: assert property (!crystal_enable && !$past(crystal_enable)
    && rc_tick |=> reference_clock) else $error("rc tick not passed to reference");
  unlock_div4_a: assert property ((loop_output_clock && !lock_q ##1 !lock_q ##1 !lock_q)
    |=> !loop_output_clock && !$past(loop_output_clock, 1) && !$past(loop_output_clock, 2))
    else $error("unlocked output faster than core over four");
  bus_half_a: assert property (bus_tick && $past(src_q) |-> $past(loop_output_clock))
    else $error("loop bus tick without loop output tick");
  pump_excl_a: assert property (!(pump_up && pump_dn))
    else $error("both pump pulses active");
  lock_window_a: assert property ($changed(lock_q) |-> $past(win_end) || $past(osc_wr))
    else $error("lock changed outside a window end");
  lock_irq_a: assert property (lock_irq ==
    ($changed(lock_q) && $past(ctl_q.lock_irq_enable))) else $error("lock interrupt mismatch");
  stable_start_a: assert property ($rose(stab_q) |->
    crystal_enable && $past(crystal_tick)) else $error("stable flag without running crystal");
  fallback_sel_a: assert property ($fell(stab_q) |-> ctl_q.loop_clock_select)
    else $error("select bit not forced on crystal loss");
  osc_clear_a: assert property (osc_wr |=> !lock_q && !stab_q)
    else $error("oscillator write did not clear status");
  switch_gap_a: assert property ($changed(src_q) |-> !bus_tick ##1 !bus_tick)
    else $error("bus tick at source switch");
  wd_resume_a: assert property ($rose(watchdog_run) && !stop_mode |-> $past(aclk_tick))
    else $error("watchdog resumed without slow tick");

  lock_seen_c:   cover property ($rose(lock_q));
  to_crystal_c:  cover property ($fell(src_q));
  fallback_c:    cover property ($fell(stab_q) && !src_q);
  apb_error_c:   cover property (pready && pslverr);

endmodule // pcg_clock_gen

// File: pcg_pkg.sv
// =====================================================================
// shared constants and types of the loop clock generator
package pcg_pkg;

  // =====================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned XTAL_LOSS_NS  = 10000;
  // longest allowed gap between crystal ticks, rounded down to cycles
  localparam logic [7:0]  XTAL_LOSS_CYC = 8'(XTAL_LOSS_NS / CLK_PERIOD_NS);
  localparam logic [1:0]  WD_RESUME     = 2'h2;

  // =====================================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OSC  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // status word and oscillator register bit positions
  localparam int unsigned ST_LOCK = 0;
  localparam int unsigned ST_XSTB = 1;
  localparam int unsigned ST_BUSX = 2;
  localparam int unsigned OSC_EN  = 0;

  // =====================================================================
  // loop configuration, low bits of the config word
  typedef struct packed {
    logic [1:0] core_range_select;
    logic [1:0] ref_range_select;
    logic [4:0] output_divider;
    logic [5:0] loop_multiplier;
    logic [3:0] ref_predivider;
  } pcg_cfg_s;

  localparam int unsigned CFG_W = $bits(pcg_cfg_s);
  localparam pcg_cfg_s CFG_RST = '{core_range_select: 2'h1, ref_range_select: 2'h0,
                                   output_divider: 5'h03, loop_multiplier: 6'h18,
                                   ref_predivider: 4'h0};

  // control word
  typedef struct packed {
    logic watchdog_stop_disable;
    logic crystal_irq_enable;
    logic lock_irq_enable;
    logic loop_clock_select;
  } pcg_ctl_s;

  localparam int unsigned CTL_W   = $bits(pcg_ctl_s);
  localparam pcg_ctl_s    CTL_RST = 4'h1;

  // =====================================================================
  // loop behaviour
  localparam logic [4:0] UNLOCK_DIV = 5'h03;
  localparam logic [7:0] LOCK_LAST  = 8'h1F;
  localparam logic [8:0] FB_EXPECT  = 9'h040;
  localparam logic [8:0] FB_MAX     = 9'h1FF;
  localparam logic [8:0] LOCK_TOL   = 9'h001;
  localparam logic [8:0] UNL_TOL    = 9'h002;

  typedef enum logic [1:0] {
    SEL_RUN   = 2'b00,
    SEL_DRAIN = 2'b01,
    SEL_SYNC  = 2'b10
  } pcg_sel_e;

endpackage

// File: pcg_divider.sv
`timescale 1ns/1ns
// =====================================================================
// divide-by-(div+1) enable pulse generator
module pcg_divider #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] div,
  output logic                  tick_out
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             tick_d;

  // >= so that a ratio lowered mid-count wraps at once instead of rolling over
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (tick_in) begin
      if (cnt_q >= div) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      tick_out <= tick_d;
    end
  end

endmodule // pcg_divider

// File: pcg_clock_gen_test.sv
`timescale 1ns/1ns
// =====================================================================
// self-checking bench: registers over apb, ticks made locally
module pcg_clock_gen_test;
  import pcg_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rc_tick;
  logic        crystal_tick;
  logic        core_osc_tick;
  logic        aclk_tick;
  logic        stop_mode;
  logic        crystal_enable;
  logic [1:0]  ref_range_select;
  logic [1:0]  core_range_select;
  logic        pump_up;
  logic        pump_dn;
  logic        loop_output_clock;
  logic        bus_tick;
  logic        lock_irq;
  logic        crystal_irq;
  logic        watchdog_run;
  int          failures = 0;
  int          n_compared = 0;
  int          n_lirq = 0;
  int          n_xirq = 0;
  int          cyc = 0;
  int          rc_p = 0;
  int          xt_p = 0;
  int          co_p = 0;
  int          ac_p = 0;
  int          lo;
  int          bt;
  logic [31:0] r;
  logic        e;

  // short start-up count keeps the crystal scenarios brief
  pcg_clock_gen #(.XTAL_START_TICKS(16'h0008)) pcg_clock_gen_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_tick(rc_tick), .crystal_tick(crystal_tick), .core_osc_tick(core_osc_tick),
    .aclk_tick(aclk_tick), .stop_mode(stop_mode), .crystal_enable(crystal_enable),
    .ref_range_select(ref_range_select), .core_range_select(core_range_select),
    .pump_up(pump_up), .pump_dn(pump_dn), .loop_output_clock(loop_output_clock),
    .bus_tick(bus_tick), .lock_irq(lock_irq), .crystal_irq(crystal_irq),
    .watchdog_run(watchdog_run)
  );

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // tick sources: a period of zero stops that source entirely
  always @(posedge pclk) begin
    cyc           <= cyc + 1;
    rc_tick       <= (rc_p != 0) && (cyc % (rc_p + (rc_p == 0)) == 0);
    crystal_tick  <= (xt_p != 0) && (cyc % (xt_p + (xt_p == 0)) == 0);
    core_osc_tick <= (co_p != 0) && (cyc % (co_p + (co_p == 0)) == 0);
    aclk_tick     <= (ac_p != 0) && (cyc % (ac_p + (ac_p == 0)) == 0);
  end

  // interrupt pulses counted on the quiet edge
  always @(negedge pclk) begin
    if (lock_irq === 1'b1) n_lirq++;
    if (crystal_irq === 1'b1) n_xirq++;
  end

  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // request held until pready is sampled high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((r & m) !== v && n < 400);
    chk(r & m, v);
  endtask

  task automatic cnt(input int n);
    lo = 0;
    bt = 0;
    repeat (20) @(negedge pclk);
    repeat (n) begin
      @(negedge pclk);
      lo += loop_output_clock;
      bt += bus_tick;
    end
  endtask

  function automatic logic [31:0] cfgw(input logic [3:0] p, input logic [5:0] m,
                                       input logic [4:0] d, input logic [1:0] rr,
                                       input logic [1:0] cr);
    return {13'h0000, cr, rr, d, m, p};
  endfunction

  // =====================================================================
  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    conclude();
  end

  // =====================================================================
  // scenarios
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; stop_mode = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({crystal_enable, ref_range_select, core_range_select, pump_up, pump_dn,
         loop_output_clock, bus_tick, lock_irq, crystal_irq, watchdog_run}, 12'h081);
    apb(1'b0, ADDR_CFG, 32'h0);  chk(r, cfgw(4'h0, 6'h18, 5'h03, 2'h0, 2'h1));
    apb(1'b0, ADDR_CTRL, 32'h0); chk(r, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0); chk(r, 32'h0);
    // unmapped place answers with an error; status cannot be written
    apb(1'b0, 8'h10, 32'h0);      chk(e, 1'b1);
    chk(r, 32'h0);
    apb(1'b1, ADDR_STAT, 32'h7);
    apb(1'b0, ADDR_STAT, 32'h0);  chk(r, 32'h0);
    // unlocked: the programmed divider of four is ignored
    co_p = 1;
    cnt(40);
    chk(lo, 10);
    chk(bt, 5);
    // lock on the internal reference, lowest multiplier, divider two
    apb(1'b1, ADDR_CTRL, 32'h7);
    apb(1'b1, ADDR_CFG, cfgw(4'h0, 6'h00, 5'h01, 2'h0, 2'h0));
    rc_p = 8; co_p = 4;
    poll(ADDR_STAT, 32'h1, 32'h1);
    chk(n_lirq, 1);
    cnt(80);
    chk(lo, 10);
    chk(bt, 5);
    // core stops: lock is lost and the enabled request fires again
    co_p = 0;
    poll(ADDR_STAT, 32'h1, 32'h0);
    chk(n_lirq, 2);
    // reference alone keeps arriving, so only the up pulse can stand
    chk({pump_up, pump_dn}, 2'b10);
    // crystal reference: internal clock gone, crystal over four
    rc_p = 0; xt_p = 2; co_p = 4;
    apb(1'b1, ADDR_CFG, cfgw(4'h3, 6'h00, 5'h01, 2'h1, 2'h0));
    @(negedge pclk);
    chk({ref_range_select, core_range_select}, 4'h4);
    apb(1'b1, ADDR_OSC, 32'h1);
    @(negedge pclk);
    chk(crystal_enable, 1'b1);
    poll(ADDR_STAT, 32'h3, 32'h3);
    chk(n_xirq, 1);
    // any accepted oscillator write drops both status bits at once
    apb(1'b1, ADDR_OSC, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);  chk(r & 32'h3, 32'h0);
    poll(ADDR_STAT, 32'h3, 32'h3);
    // bus moves to the crystal; oscillator register now locked out
    apb(1'b1, ADDR_CTRL, 32'h6);
    poll(ADDR_STAT, 32'h4, 32'h4);
    cnt(40);
    chk(bt, 20);
    apb(1'b1, ADDR_OSC, 32'h0);
    apb(1'b0, ADDR_OSC, 32'h0);  chk(r, 32'h1);
    // crystal dies: hardware returns the bus to the loop
    xt_p = 0;
    poll(ADDR_STAT, 32'h6, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);  chk(r & 32'h1, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h6);
    apb(1'b0, ADDR_CTRL, 32'h0);  chk(r & 32'h1, 32'h1);
    // watchdog held through stop, resumes after two slow ticks;
    // both interrupt enables are cleared before stop
    apb(1'b1, ADDR_CTRL, 32'h9);
    ac_p = 10;
    @(posedge pclk) stop_mode <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(watchdog_run, 1'b0);
    @(posedge pclk) stop_mode <= 1'b0;
    repeat (5) @(negedge pclk);
    chk(watchdog_run, 1'b0);
    repeat (25) @(negedge pclk);
    chk(watchdog_run, 1'b1);
    // without the stop-disable bit the watchdog keeps running through stop
    apb(1'b1, ADDR_CTRL, 32'h1);
    @(posedge pclk) stop_mode <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(watchdog_run, 1'b1);
    @(posedge pclk) stop_mode <= 1'b0;
    conclude();
  end

endmodule // pcg_clock_gen_test
